// *** verilog/rdp_rx_desc_pointer.sv ***
// Receive descriptor pointer and its walk along the descriptor list.
// Assumes a same-clock register port and a descriptor fetch engine
// that answers each fetch request with the link field of that descriptor.
`timescale 1ns/1ps
`include "rdp_consts.svh"
module rdp_rx_desc_pointer (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [`RDP_ADDR_W-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	input wire logic i_link_valid,
	input wire logic [31:0] i_link_data,
	input wire logic i_desc_done,
	input wire logic i_rx_idle,
	output logic o_fetch_req,
	output logic [31:0] o_fetch_addr,
	output logic o_dma_enable,
	output logic o_wake_on_lan_mode
);
	// ********************************
	// Register port decode
	// ********************************
	// Addresses match on the whole byte offset; software reaches the
	// registers only at their word addresses.
	function automatic logic hit(input logic [`RDP_ADDR_W-1:0] a,
		input logic [`RDP_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// Descriptors sit on word boundaries, so the two low bits are cut off
	// wherever an address enters the pointer.
	function automatic logic [31:0] word_align(input logic [31:0] a);
		word_align = a & `RDP_ALIGN_MASK;
	endfunction

	// A zero word is both the end of the list and the silent request.
	function automatic logic is_null(input logic [31:0] a);
		is_null = (a == `RDP_ZERO32);
	endfunction

	rdp_pkg::rdp_bus_req_t req;
	rdp_pkg::rdp_link_t link;

	assign req = '{addr: i_reg_addr, wdata: i_reg_wdata,
		wr: i_reg_wr, rd: i_reg_rd};
	assign link = '{valid: i_link_valid, link: i_link_data};

	logic ptr_wr;
	logic enable_wr;
	logic ptr_rd;
	logic status_rd;

	assign ptr_wr = req.wr && hit(req.addr, `RDP_OFS_POINTER);
	assign enable_wr = req.wr && hit(req.addr, `RDP_OFS_COMMAND)
		&& req.wdata[`RDP_CMD_RX_ENABLE_BIT];
	assign ptr_rd = req.rd && hit(req.addr, `RDP_OFS_POINTER);
	assign status_rd = req.rd && hit(req.addr, `RDP_OFS_STATUS);

	// ********************************
	// Walk decode
	// ********************************
	// Reset leaves a null pointer, which is also the silent request; an
	// enable write before any pointer load therefore enters silent mode
	// rather than fetching from address zero.
	rdp_pkg::rdp_state_t state_q;
	rdp_pkg::rdp_state_t state_d;
	logic [31:0] rx_desc_pointer_q;
	logic [31:0] rx_desc_pointer_d;
	logic at_rest;
	logic in_fetch;
	logic in_link_read;
	logic in_parked;
	logic start_fetch;
	logic enter_silent;
	logic link_advance;
	logic link_park;
	logic reread;

	// Idle and silent are the two resting states; only there does an
	// enable write choose between a fresh fetch and silent receive.
	assign at_rest = (state_q == rdp_pkg::RDP_IDLE)
		|| (state_q == rdp_pkg::RDP_SILENT);
	assign in_fetch = (state_q == rdp_pkg::RDP_FETCH);
	assign in_link_read = (state_q == rdp_pkg::RDP_LINK_READ);
	assign in_parked = (state_q == rdp_pkg::RDP_PARKED);

	assign start_fetch = at_rest && enable_wr
		&& !is_null(rx_desc_pointer_q);
	assign enter_silent = at_rest && enable_wr
		&& is_null(rx_desc_pointer_q);
	assign link_advance = in_link_read && link.valid
		&& !is_null(link.link);
	assign link_park = in_link_read && link.valid
		&& is_null(link.link);
	// Every enable write while parked re-reads the link, not only the
	// first one, so descriptors appended late are still found.
	assign reread = in_parked && enable_wr;

	// ********************************
	// Walk state machine
	// ********************************
	always_comb begin
		state_d = state_q;
		case (state_q)
		rdp_pkg::RDP_IDLE, rdp_pkg::RDP_SILENT: begin
			if (start_fetch) begin
				state_d = rdp_pkg::RDP_FETCH;
			end else if (enter_silent) begin
				state_d = rdp_pkg::RDP_SILENT;
			end
		end
		rdp_pkg::RDP_FETCH: begin
			// The first answer is the descriptor itself; its link is
			// used only after that descriptor is done.
			if (in_fetch && link.valid) begin
				state_d = rdp_pkg::RDP_ACTIVE;
			end
		end
		rdp_pkg::RDP_ACTIVE: begin
			if (i_desc_done) begin
				state_d = rdp_pkg::RDP_LINK_READ;
			end else if (i_rx_idle) begin
				state_d = rdp_pkg::RDP_IDLE;
			end
		end
		rdp_pkg::RDP_LINK_READ: begin
			if (link_park) begin
				state_d = rdp_pkg::RDP_PARKED;
			end else if (link_advance) begin
				state_d = rdp_pkg::RDP_ACTIVE;
			end
		end
		rdp_pkg::RDP_PARKED: begin
			if (reread) begin
				state_d = rdp_pkg::RDP_LINK_READ;
			end else if (i_rx_idle) begin
				state_d = rdp_pkg::RDP_IDLE;
			end
		end
		default: begin
			state_d = rdp_pkg::RDP_IDLE;
		end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= rdp_pkg::RDP_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ********************************
	// Descriptor pointer
	// ********************************
	// Software writes land in any state, except in a cycle where a link advance loads the pointer. A write while the walk is
	// active loses the engine's place; keeping clear of that is left to
	// software, since the walk cannot tell a stale write from a new one.
	always_comb begin
		rx_desc_pointer_d = rx_desc_pointer_q;
		if (link_advance) begin
			rx_desc_pointer_d = word_align(link.link);
		end else if (ptr_wr) begin
			rx_desc_pointer_d = word_align(req.wdata);
		end
		// A null link leaves the pointer on the last descriptor.
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_desc_pointer_q <= `RDP_POINTER_RESET;
		end else begin
			rx_desc_pointer_q <= rx_desc_pointer_d;
		end
	end

	// ********************************
	// Fetch request
	// ********************************
	// The request is a level, not a pulse, so the fetch engine may take
	// as many cycles as it needs before it answers.
	logic fetch_req_q;
	logic fetch_req_d;

	always_comb begin
		fetch_req_d = 1'b0;
		case (state_q)
		rdp_pkg::RDP_IDLE, rdp_pkg::RDP_SILENT: begin
			fetch_req_d = start_fetch;
		end
		rdp_pkg::RDP_FETCH, rdp_pkg::RDP_LINK_READ: begin
			// Held until the answer, so a slow memory never misses it.
			fetch_req_d = !link.valid;
		end
		rdp_pkg::RDP_ACTIVE: begin
			fetch_req_d = i_desc_done;
		end
		rdp_pkg::RDP_PARKED: begin
			fetch_req_d = reread;
		end
		default: begin
			fetch_req_d = 1'b0;
		end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fetch_req_q <= 1'b0;
		end else begin
			fetch_req_q <= fetch_req_d;
		end
	end

	// ********************************
	// Receive mode flags
	// ********************************
	logic dma_q;
	logic dma_d;
	logic wol_q;
	logic wol_d;

	// Silent mode only gates the transfers to memory; the receive FIFO
	// keeps filling, so a later start drains what arrived meanwhile.
	always_comb begin
		dma_d = dma_q;
		wol_d = wol_q;
		if (enter_silent) begin
			dma_d = 1'b0;
			wol_d = 1'b1;
		end else if (start_fetch) begin
			dma_d = 1'b1;
			wol_d = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dma_q <= 1'b0;
			wol_q <= 1'b0;
		end else begin
			dma_q <= dma_d;
			wol_q <= wol_d;
		end
	end

	// ********************************
	// Read data
	// ********************************
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Status layout: walk state in the low bits, then the two mode flags.
	function automatic logic [31:0] status_word(
		input rdp_pkg::rdp_state_t st,
		input logic dma,
		input logic wake_on_lan_mode);
		status_word = {27'h000_0000, wake_on_lan_mode, dma, st};
	endfunction

	// Read data stand for one cycle only and return to zero, so an
	// unmapped or absent read never shows a stale word.
	always_comb begin
		rdata_d = `RDP_ZERO32;
		if (ptr_rd) begin
			rdata_d = rx_desc_pointer_q;
		end else if (status_rd) begin
			rdata_d = status_word(state_q, dma_q, wol_q);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_q <= `RDP_ZERO32;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	// Every output is a register, so neither the bus nor the fetch
	// engine sees a combinational path through this block.
	assign o_reg_rdata = rdata_q;
	assign o_fetch_req = fetch_req_q;
	assign o_fetch_addr = rx_desc_pointer_q;
	assign o_dma_enable = dma_q;
	assign o_wake_on_lan_mode = wol_q;
endmodule

// *** shared/rdp_consts.svh ***
// Constants of the receive descriptor pointer block.
// Assumes inclusion by the package and the design file by bare name.
`ifndef RDP_CONSTS_SVH
`define RDP_CONSTS_SVH
`define RDP_ADDR_W 8
`define RDP_OFS_POINTER 8'h30
`define RDP_OFS_COMMAND 8'h04
`define RDP_OFS_STATUS 8'h38
`define RDP_POINTER_RESET 32'h0000_0000
`define RDP_ALIGN_MASK 32'hFFFF_FFFC
`define RDP_CMD_RX_ENABLE_BIT 2
`define RDP_ZERO32 32'h0000_0000
`endif

// *** shared/rdp_pkg.sv ***
// Types of the receive descriptor pointer block.
// Assumes the constants header is on the include path.
`include "rdp_consts.svh"
package rdp_pkg;
	typedef enum logic [2:0] {
		RDP_IDLE,
		RDP_FETCH,
		RDP_ACTIVE,
		RDP_LINK_READ,
		RDP_PARKED,
		RDP_SILENT
	} rdp_state_t;

	typedef struct packed {
		logic [`RDP_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} rdp_bus_req_t;

	typedef struct packed {
		logic valid;
		logic [31:0] link;
	} rdp_link_t;
endpackage

// *** test/rdp_desc_mem.sv ***
// Descriptor list model answering link reads of the pointer block.
// Assumes the bench fills lk; addresses with bit 4 set answer slowly.
`timescale 1ns/1ps
module rdp_desc_mem(
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic i_done,
	input wire logic [31:0] i_addr,
	output logic o_valid,
	output logic [31:0] o_link
);
	logic [31:0] lk [16];
	logic [31:0] last = 32'h0000_0000;
	int w = -1;
	initial o_valid = 0;
	// Idle link data is inverted so stale values never look valid.
	always @(posedge i_clk) begin
		o_valid <= 0;
		o_link <= ~last;
		if (w > 0)
			w <= w - 1;
		if (w == 0) begin
			o_valid <= 1;
			o_link <= lk[i_addr[5:2]];
			last <= lk[i_addr[5:2]];
			w <= -1;
		end else if (w < 0 && (i_done || i_req && !o_valid))
			w <= i_addr[4] ? 3 : 0;
	end
endmodule

// *** test/rdp_checker.sv ***
// Port checker of the pointer block.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "rdp_consts.svh"
module rdp_checker(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [`RDP_ADDR_W-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_link_valid,
	input wire logic [31:0] i_link_data,
	input wire logic o_fetch_req,
	input wire logic [31:0] o_fetch_addr,
	input wire logic o_dma_enable,
	input wire logic o_wake_on_lan_mode
);
	wire en = i_reg_wr && i_reg_addr == `RDP_OFS_COMMAND
		&& i_reg_wdata[`RDP_CMD_RX_ENABLE_BIT];
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	AST_HOLD: assert property (o_fetch_req && !i_link_valid |=>
		o_fetch_req) else $error("fetch dropped early");
	AST_DROP: assert property (o_fetch_req && i_link_valid |=>
		!o_fetch_req) else $error("fetch held too long");
	AST_NULL: assert property (i_link_valid && i_link_data == 0
		&& !i_reg_wr |=> $stable(o_fetch_addr)) else $error("moved");
	AST_SILENT: assert property (o_wake_on_lan_mode |->
		!o_dma_enable) else $error("dma in silent mode");
	AST_ALIGN: assert property (o_fetch_addr[1:0] == 2'h0)
		else $error("pointer not aligned");
	AST_ZERO: assert property (en && o_fetch_addr == 0 && !o_dma_enable
		|=> o_wake_on_lan_mode && !o_dma_enable) else $error("no silent");
	AST_START: assert property (en && o_fetch_addr != 0 && !o_dma_enable
		|=> o_fetch_req && o_dma_enable) else $error("no start");
	AST_PTR: assert property (i_reg_wr && i_reg_addr == `RDP_OFS_POINTER
		&& !o_dma_enable |=> o_fetch_addr == (`RDP_ALIGN_MASK
		& $past(i_reg_wdata))) else $error("pointer write lost");
endmodule
bind rdp_rx_desc_pointer rdp_checker chk(.*);

// *** test/rdp_rx_desc_pointer_bench.sv ***
// Self-checking bench of the pointer block.
// Assumes the descriptor model and checker are compiled first.
`timescale 1ns/1ps
`include "rdp_consts.svh"
module rdp_rx_desc_pointer_bench;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, done = 0, idle = 0, lv;
	logic fr, dma, wake_on_lan_mode;
	logic [7:0] a = 8'h00;
	logic [31:0] wd = 32'h0000_0000, rdat, fa, ld;
	logic [15:0] lf = 16'hFA6F;
	int n_errors = 0, num_checks = 0;
	always #2.5 clk = ~clk;
	rdp_rx_desc_pointer dut(.i_core_clk(clk), .i_resetn(rstn),
		.i_reg_addr(a), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdat), .i_link_valid(lv), .i_link_data(ld),
		.i_desc_done(done), .i_rx_idle(idle), .o_fetch_req(fr),
		.o_fetch_addr(fa), .o_dma_enable(dma), .o_wake_on_lan_mode(wake_on_lan_mode));
	rdp_desc_mem mem(.i_clk(clk), .i_req(fr), .i_done(done),
		.i_addr(fa), .o_valid(lv), .o_link(ld));
	task automatic chk(input string n, input logic [31:0] e, s);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [31:0] exp_ptr(input logic [31:0] v);
		exp_ptr = v & `RDP_ALIGN_MASK;
	endfunction
	function automatic logic [31:0] exp_status(input logic [2:0] st,
		input logic d, w);
		exp_status = {27'h000_0000, w, d, st};
	endfunction
	task automatic wrt(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk) begin a <= ad; wd <= d; wr <= 1; end
		@(posedge clk) wr <= 0;
	endtask
	task automatic rdc(input string n, input logic [7:0] ad,
		input logic [31:0] e);
		@(posedge clk) begin a <= ad; rd <= 1; end
		@(posedge clk) rd <= 0;
		#1 chk(n, e, rdat);
	endtask
	task automatic ev(input logic en, d, i);
		if (en)
			wrt(`RDP_OFS_COMMAND, 32'h0000_0004);
		@(posedge clk) begin done <= d; idle <= i; end
		@(posedge clk) begin done <= 0; idle <= 0; end
		repeat (12) @(posedge clk);
		#1 $display("step done");
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// The run needs under 150 cycles; this limit is 4000 cycles, over twenty-five times that.
	initial begin
		#20000 n_errors++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1;
		rdc("reset", `RDP_OFS_POINTER, 32'h0000_0000);
		repeat (4) begin
			lf = lfsr(lf);
			wrt(`RDP_OFS_POINTER, {lf, lf});
			rdc("ptr", `RDP_OFS_POINTER, exp_ptr({lf, lf}));
		end
		rdc("unmapped", 8'h3C, 32'h0000_0000);
		mem.lk[4] = 32'h0000_0020;
		mem.lk[8] = 32'h0000_0000;
		wrt(`RDP_OFS_POINTER, 32'h0000_0010);
		ev(1, 0, 0);
		chk("first", 32'h0000_0010, fa);
		ev(0, 1, 0);
		chk("next", 32'h0000_0020, fa);
		ev(0, 1, 0);
		chk("end", 32'h0000_0020, fa);
		mem.lk[8] = 32'h0000_0030;
		ev(1, 0, 0);
		chk("reread", 32'h0000_0030, fa);
		ev(0, 0, 1);
		wrt(`RDP_OFS_POINTER, 32'h0000_0000);
		ev(1, 0, 0);
		chk("silent", 32'h0000_0001, {30'h0, dma, wake_on_lan_mode});
		rdc("status", `RDP_OFS_STATUS, exp_status(3'h5, 1'b0, 1'b1));
		wrt(`RDP_OFS_POINTER, 32'h0000_0010);
		ev(1, 0, 0);
		chk("drain", 32'h0000_0002, {30'h0, dma, wake_on_lan_mode});
		rdc("status", `RDP_OFS_STATUS, exp_status(3'h2, 1'b1, 1'b0));
		conclude();
	end
endmodule
